/* hw/adc_cmd_pkg.sv */
// Behaviour
// - 0000000X leaves, 0000001X enters low power
// - 0000010X synchronises, 0000011X resets registers
// - 10h continuous, 11h stop, 12h single read
// - Register read: 20h plus address, count
// - Register write: 40h plus address, count, data
// - Count byte holds registers minus one
// - Read data driven from sixteenth falling edge
// - Leave-low-power exits standby, else ignored
// - Standby stops conversions, keeps registers, port
// - Power-down pin low loses all registers
// - Synchronise abandons and restarts conversion
// - Reset command equals reset pin
// - Continuous mode presents each new result
// - Stop-continuous hides ready, conversions continue
// - Offset calibration averages sixteen, bypasses gain
// - Gain calibration stores gain correction value
// - Ready returns 64 periods after synchronise
// - Calibration completes within sixteen data periods
// - No calibration while sinc path selected
// - Result MSB first, then output low
// - Register write mutes output 63 readings
package adc_cmd_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] OP_CONT_ON = 8'h10;
  localparam logic [7:0] OP_CONT_OFF = 8'h11;
  localparam logic [7:0] OP_READ_ONE = 8'h12;
  localparam logic [7:0] OP_OFFSET_CAL = 8'h60;
  localparam logic [7:0] OP_GAIN_CAL = 8'h61;
  localparam logic [2:0] OP_REG_READ_HI = 3'h1;
  localparam logic [2:0] OP_REG_WRITE_HI = 3'h2;

  // ==========================================================
  // Register map
  localparam int REG_COUNT = 11;
  localparam logic [4:0] REG_ID = 5'h00;
  localparam logic [4:0] REG_CONFIG0 = 5'h01;
  localparam logic [4:0] REG_CONFIG1 = 5'h02;
  localparam logic [4:0] REG_OFFSET0 = 5'h05;
  localparam logic [4:0] REG_GAIN0 = 5'h08;
  localparam logic [4:0] REG_LAST = 5'h0A;
  localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {
    8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h32, 8'h08, 8'h52, 8'h00
  };
  localparam logic [1:0] FILTER_SINC = 2'h1;

  // ==========================================================
  // Counts
  localparam logic [6:0] MUTE_SYNC = 7'h40;
  localparam logic [6:0] MUTE_WRITE = 7'h3F;
  localparam logic [6:0] MUTE_CAL = 7'h10;
  localparam logic [4:0] CAL_LAST = 5'h0F;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int FIFO_DEPTH = 4;
  localparam int WORD_BITS = 32;

  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_RD_COUNT = 3'b001,
    ST_RD_DATA = 3'b010,
    ST_WR_COUNT = 3'b011,
    ST_WR_DATA = 3'b100
  } port_state_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [4:0] left;
  } reg_xfer_t;

endpackage

/* hw/result_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module result_fifo
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      // Wrap explicitly so any depth works
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* hw/adc_serial_command_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_serial_command_decoder
  import adc_cmd_pkg::*;
#(
  parameter logic [3:0] ID_CODE = 4'h5, // arbitrary value
  parameter int FIFO_WORDS = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Serial port pins
  input wire logic i_sclk,
  input wire logic i_din,
  output logic o_dout,
  output logic o_result_ready_n,
  input wire logic i_power_down_n,
  // Conversion source
  input wire logic i_conv_valid,
  input wire logic [WORD_BITS-1:0] i_conv_data,
  output logic o_conv_ready,
  output logic o_conv_restart,
  output logic o_standby,
  // Correction control
  output logic o_gain_bypass,
  output logic o_corr_enable,
  output logic [23:0] o_offset_correction,
  output logic [23:0] o_gain_correction,
  output logic [7:0] o_config0,
  output logic [7:0] o_config1
);

  // ==========================================================
  // Pin synchronisers
  logic [2:0] sclk_s_reg;
  logic [2:0] din_s_reg;
  logic [2:0] pd_s_reg;
  logic sclk_lvl_reg;
  logic din_lvl_reg;
  logic pd_lvl_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic power_down;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sclk_s_reg <= '0;
      din_s_reg <= '0;
      pd_s_reg <= 3'h7;
      sclk_lvl_reg <= 1'b0;
      din_lvl_reg <= 1'b0;
      pd_lvl_reg <= 1'b1;
    end
    else
    begin
      sclk_s_reg <= {sclk_s_reg[1:0], i_sclk};
      din_s_reg <= {din_s_reg[1:0], i_din};
      pd_s_reg <= {pd_s_reg[1:0], i_power_down_n};
      if (sclk_s_reg[1] == sclk_s_reg[2])
      begin
        sclk_lvl_reg <= sclk_s_reg[2];
      end
      if (din_s_reg[1] == din_s_reg[2])
      begin
        din_lvl_reg <= din_s_reg[2];
      end
      if (pd_s_reg[1] == pd_s_reg[2])
      begin
        pd_lvl_reg <= pd_s_reg[2];
      end
    end
  end

  assign sclk_rise = (sclk_s_reg[1] == sclk_s_reg[2]) && sclk_s_reg[2] && !sclk_lvl_reg;
  assign sclk_fall = (sclk_s_reg[1] == sclk_s_reg[2]) && !sclk_s_reg[2] && sclk_lvl_reg;
  assign power_down = !pd_lvl_reg;

  // ==========================================================
  // Byte receiver
  logic [6:0] rx_shift_reg;
  logic [2:0] bit_cnt_reg;
  logic byte_done;
  logic [7:0] rx_byte;
  logic soft_rst;

  // Data line is taken from din_lvl_reg, one stage behind the edge detect on sclk_s_reg
  assign rx_byte = {rx_shift_reg, din_lvl_reg};
  assign byte_done = sclk_rise && (bit_cnt_reg == BIT_LAST);

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_shift_reg <= '0;
      bit_cnt_reg <= '0;
    end
    else if (power_down)
    begin
      rx_shift_reg <= '0;
      bit_cnt_reg <= '0;
    end
    else if (sclk_rise)
    begin
      rx_shift_reg <= rx_byte[6:0];
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
  end

  // ==========================================================
  // Command decode
  port_state_t state_reg;
  reg_xfer_t xfer_reg;
  logic op_byte;
  logic cmd_wake;
  logic cmd_standby;
  logic cmd_sync;
  logic cmd_reset;
  logic cmd_cont_on;
  logic cmd_cont_off;
  logic cmd_read_one;
  logic cmd_offset_cal;
  logic cmd_gain_cal;
  logic reg_write;

  assign op_byte = byte_done && (state_reg == ST_OPCODE);
  assign cmd_wake = op_byte && (rx_byte[7:1] == 7'h00);
  assign cmd_standby = op_byte && (rx_byte[7:1] == 7'h01);
  assign cmd_sync = op_byte && (rx_byte[7:1] == 7'h02);
  assign cmd_reset = op_byte && (rx_byte[7:1] == 7'h03);
  assign cmd_cont_on = op_byte && (rx_byte == OP_CONT_ON);
  assign cmd_cont_off = op_byte && (rx_byte == OP_CONT_OFF);
  assign cmd_read_one = op_byte && (rx_byte == OP_READ_ONE);
  assign cmd_offset_cal = op_byte && (rx_byte == OP_OFFSET_CAL);
  assign cmd_gain_cal = op_byte && (rx_byte == OP_GAIN_CAL);
  assign reg_write = byte_done && (state_reg == ST_WR_DATA);

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= ST_OPCODE;
      xfer_reg <= '0;
    end
    else if (power_down)
    begin
      state_reg <= ST_OPCODE;
      xfer_reg <= '0;
    end
    else if (byte_done)
    begin
      case (state_reg)
        ST_OPCODE:
        begin
          xfer_reg.addr <= rx_byte[4:0];
          if (rx_byte[7:5] == OP_REG_READ_HI)
          begin
            state_reg <= ST_RD_COUNT;
          end
          else if (rx_byte[7:5] == OP_REG_WRITE_HI)
          begin
            state_reg <= ST_WR_COUNT;
          end
        end
        ST_RD_COUNT:
        begin
          xfer_reg.left <= rx_byte[4:0];
          state_reg <= ST_RD_DATA;
        end
        ST_WR_COUNT:
        begin
          xfer_reg.left <= rx_byte[4:0];
          state_reg <= ST_WR_DATA;
        end
        ST_RD_DATA, ST_WR_DATA:
        begin
          xfer_reg.addr <= xfer_reg.addr + 1'b1;
          xfer_reg.left <= xfer_reg.left - 1'b1;
          if (xfer_reg.left == '0)
          begin
            state_reg <= ST_OPCODE;
          end
        end
        default:
        begin
          state_reg <= ST_OPCODE;
        end
      endcase
    end
  end

  // ==========================================================
  // Register file
  logic [REG_COUNT-1:0][7:0] regs_reg;
  logic cal_done;
  logic cal_gain_reg;
  logic [23:0] cal_value;
  logic sinc_path;

  function automatic logic [7:0] reg_read(input logic [4:0] addr,
                                          input logic [REG_COUNT-1:0][7:0] regs);
    if (addr == REG_ID)
    begin
      reg_read = {ID_CODE, 4'h0};
    end
    else if (addr <= REG_LAST)
    begin
      reg_read = regs[addr];
    end
    else
    begin
      reg_read = 8'h00;
    end
  endfunction

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      regs_reg <= REG_RESET;
    end
    else if (soft_rst)
    begin
      regs_reg <= REG_RESET;
    end
    else if (cal_done)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (cal_gain_reg)
        begin
          regs_reg[REG_GAIN0 + 5'(i)] <= cal_value[8*i +: 8];
        end
        else
        begin
          regs_reg[REG_OFFSET0 + 5'(i)] <= cal_value[8*i +: 8];
        end
      end
    end
    else if (reg_write && (xfer_reg.addr != REG_ID) && (xfer_reg.addr <= REG_LAST))
    begin
      regs_reg[xfer_reg.addr] <= rx_byte;
    end
  end

  assign o_config0 = regs_reg[REG_CONFIG0];
  assign o_config1 = regs_reg[REG_CONFIG1];
  assign o_offset_correction = {regs_reg[REG_OFFSET0 + 5'h2], regs_reg[REG_OFFSET0 + 5'h1],
                                regs_reg[REG_OFFSET0]};
  assign o_gain_correction = {regs_reg[REG_GAIN0 + 5'h2], regs_reg[REG_GAIN0 + 5'h1],
                              regs_reg[REG_GAIN0]};
  assign sinc_path = (regs_reg[REG_CONFIG0][1:0] == FILTER_SINC);
  assign o_corr_enable = !sinc_path;

  // ==========================================================
  // Operating modes
  logic cont_reg;
  logic standby_reg;
  logic read_one_reg;
  logic restart_reg;
  logic reset_cmd_reg;
  logic [6:0] mute_reg;
  logic pop;
  logic present;
  logic cal_start;

  assign soft_rst = power_down || reset_cmd_reg;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cont_reg <= 1'b1;
      standby_reg <= 1'b0;
      read_one_reg <= 1'b0;
      restart_reg <= 1'b0;
      reset_cmd_reg <= 1'b0;
      mute_reg <= '0;
    end
    else
    begin
      reset_cmd_reg <= cmd_reset;
      restart_reg <= soft_rst || cmd_sync || reg_write;
      if (soft_rst)
      begin
        cont_reg <= 1'b1;
        // Pin power-down shows as standby directly, so release wakes at once
        standby_reg <= 1'b0;
        read_one_reg <= 1'b0;
        mute_reg <= '0;
      end
      else
      begin
        if (cmd_standby)
        begin
          standby_reg <= 1'b1;
        end
        else if (cmd_wake)
        begin
          standby_reg <= 1'b0;
        end
        if (cmd_cont_on)
        begin
          cont_reg <= 1'b1;
        end
        else if (cmd_cont_off)
        begin
          cont_reg <= 1'b0;
        end
        if (cmd_read_one)
        begin
          read_one_reg <= 1'b1;
        end
        else if (present)
        begin
          read_one_reg <= 1'b0;
        end
        // Readings that follow a synchronise or register-write restart are unsettled, so they are withheld
        if (cmd_sync)
        begin
          mute_reg <= MUTE_SYNC;
        end
        else if (reg_write)
        begin
          mute_reg <= MUTE_WRITE;
        end
        else if (cal_start)
        begin
          mute_reg <= MUTE_CAL;
        end
        else if (pop && (mute_reg != '0))
        begin
          mute_reg <= mute_reg - 1'b1;
        end
      end
    end
  end

  assign o_conv_restart = restart_reg;
  assign o_standby = standby_reg || power_down;

  // ==========================================================
  // Result buffer
  logic fifo_valid;
  logic [WORD_BITS-1:0] fifo_data;
  logic drain_ready;

  // A register read owns the output line, so results back up meanwhile
  assign drain_ready = !standby_reg && !power_down && (state_reg != ST_RD_DATA);
  assign pop = fifo_valid && drain_ready;
  assign present = pop && (mute_reg == '0) && (cont_reg || read_one_reg);

  result_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_valid(i_conv_valid),
    .i_in_data(i_conv_data),
    .o_in_ready(o_conv_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(drain_ready)
  );

  // ==========================================================
  // Output shifter
  logic [WORD_BITS-1:0] out_reg;
  logic ready_n_reg;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      out_reg <= '0;
      ready_n_reg <= 1'b1;
    end
    else if (soft_rst)
    begin
      out_reg <= '0;
      ready_n_reg <= 1'b1;
    end
    else if (present)
    begin
      out_reg <= fifo_data;
      ready_n_reg <= 1'b0;
    end
    else if (sclk_fall)
    begin
      ready_n_reg <= 1'b1;
      if ((state_reg == ST_RD_DATA) && (bit_cnt_reg == '0))
      begin
        out_reg <= {reg_read(xfer_reg.addr, regs_reg), 24'h000000};
      end
      else
      begin
        out_reg <= {out_reg[WORD_BITS-2:0], 1'b0};
      end
    end
  end

  assign o_dout = out_reg[WORD_BITS-1];
  assign o_result_ready_n = ready_n_reg;

  // ==========================================================
  // Calibration engine
  logic cal_active_reg;
  logic [4:0] cal_cnt_reg;
  logic [35:0] cal_sum_reg;
  logic [35:0] cal_total;

  assign cal_start = (cmd_offset_cal || cmd_gain_cal) && !sinc_path;
  assign cal_total = cal_sum_reg + {{4{fifo_data[WORD_BITS-1]}}, fifo_data};
  assign cal_done = cal_active_reg && pop && (cal_cnt_reg == CAL_LAST);
  // Average of sixteen is the sum shifted by four; top 24 bits kept
  assign cal_value = cal_total[35:12];
  assign o_gain_bypass = cal_active_reg && !cal_gain_reg;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cal_active_reg <= 1'b0;
      cal_gain_reg <= 1'b0;
      cal_cnt_reg <= '0;
      cal_sum_reg <= '0;
    end
    else if (soft_rst || cmd_sync || reg_write)
    begin
      cal_active_reg <= 1'b0;
      cal_cnt_reg <= '0;
      cal_sum_reg <= '0;
    end
    else if (cal_start)
    begin
      cal_active_reg <= 1'b1;
      cal_gain_reg <= cmd_gain_cal;
      cal_cnt_reg <= '0;
      cal_sum_reg <= '0;
    end
    else if (cal_active_reg && pop)
    begin
      cal_sum_reg <= cal_total;
      cal_cnt_reg <= cal_cnt_reg + 1'b1;
      if (cal_done)
      begin
        cal_active_reg <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* verification/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // Serial pins
  output logic o_sclk,
  output logic o_din,
  input wire logic i_dout
);
  localparam realtime HALF_NS = 62.5;
  // Well above 24 clocks, so no byte lands inside the spacing window
  localparam realtime GAP_NS = 200.0;

  initial
  begin
    o_sclk = 1'b0;
    o_din = 1'b1;
  end

  // ==========================================================
  // One byte out and in; clock rests low between bytes
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      o_din = tx[i];
      #HALF_NS;
      o_sclk = 1'b1;
      rx[i] = i_dout;
      #HALF_NS;
      o_sclk = 1'b0;
    end
    o_din = ~tx[0];
    #GAP_NS;
  endtask
endmodule
`default_nettype wire

/* verification/adc_cmd_decoder_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_cmd_decoder_properties
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Watched ports
  input wire logic i_sclk,
  input wire logic i_power_down_n,
  input wire logic o_dout,
  input wire logic o_result_ready_n,
  input wire logic o_conv_ready,
  input wire logic o_conv_restart,
  input wire logic o_standby,
  input wire logic o_gain_bypass,
  input wire logic o_corr_enable,
  input wire logic [23:0] o_offset_correction,
  input wire logic [23:0] o_gain_correction,
  input wire logic [7:0] o_config0
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // ==========================================================
  // Recent pin activity, covering the synchroniser latency
  logic [7:0] sclk_hist_reg;
  logic [7:0] pd_hist_reg;
  logic edge_seen;
  logic pd_ok;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      sclk_hist_reg <= 8'h00;
    else
      sclk_hist_reg <= {sclk_hist_reg[6:0], i_sclk};
  end
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      pd_hist_reg <= 8'hFF;
    else
      pd_hist_reg <= {pd_hist_reg[6:0], i_power_down_n};
  end
  assign edge_seen = (|sclk_hist_reg) && !(&sclk_hist_reg);
  assign pd_ok = &pd_hist_reg;

  sequence pd_held;
    !i_power_down_n [*6];
  endsequence

  // ==========================================================
  // Properties
  chk_full_holds: assert property (
    o_standby && !o_conv_ready && pd_ok |=> !o_conv_ready)
    else $error("fifo drained during standby");
  chk_standby_quiet: assert property (
    o_standby && $past(o_standby) && o_result_ready_n && pd_ok |=> o_result_ready_n)
    else $error("result presented during standby");
  chk_pd_standby: assert property (
    pd_held |-> o_standby && o_conv_restart)
    else $error("power-down did not hold the converter off");
  chk_pd_defaults: assert property (
    pd_held |-> o_config0 == 8'h52 && o_offset_correction == 24'h000000
      && o_gain_correction == 24'h400000)
    else $error("power-down kept register contents");
  chk_sinc_corr: assert property (
    o_corr_enable == (o_config0[1:0] != 2'h1))
    else $error("correction enable does not follow filter path");
  chk_bypass_corr: assert property (
    o_gain_bypass |-> o_corr_enable)
    else $error("calibration running on the sinc path");
  chk_ready_cause: assert property (
    $rose(o_result_ready_n) |-> edge_seen || !pd_ok)
    else $error("ready released without serial clock");
  chk_restart_cause: assert property (
    o_conv_restart |-> edge_seen || !pd_ok)
    else $error("restart without command or power-down");
  chk_config_cause: assert property (
    !$stable(o_config0) |-> edge_seen || !pd_ok)
    else $error("config changed without a command");
  chk_dout_cause: assert property (
    !$stable(o_dout) |-> edge_seen || !pd_ok || !o_result_ready_n)
    else $error("data output moved without clock or result");
endmodule

bind adc_serial_command_decoder adc_cmd_decoder_properties chk_u (
  .i_sys_clk(i_sys_clk),
  .i_rst(i_rst),
  .i_sclk(i_sclk),
  .i_power_down_n(i_power_down_n),
  .o_dout(o_dout),
  .o_result_ready_n(o_result_ready_n),
  .o_conv_ready(o_conv_ready),
  .o_conv_restart(o_conv_restart),
  .o_standby(o_standby),
  .o_gain_bypass(o_gain_bypass),
  .o_corr_enable(o_corr_enable),
  .o_offset_correction(o_offset_correction),
  .o_gain_correction(o_gain_correction),
  .o_config0(o_config0)
);
`default_nettype wire

/* verification/tb_adc_serial_command_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_serial_command_decoder;
  import adc_cmd_pkg::*;
  localparam logic [3:0] ID_VAL = 4'h9; // arbitrary value
  logic i_sys_clk;
  logic i_rst;
  logic i_sclk;
  logic i_din;
  logic i_power_down_n;
  logic i_conv_valid;
  logic [WORD_BITS-1:0] i_conv_data;
  logic o_dout;
  logic o_result_ready_n;
  logic o_conv_ready;
  logic o_conv_restart;
  logic o_standby;
  logic o_gain_bypass;
  logic o_corr_enable;
  logic [23:0] o_offset_correction;
  logic [23:0] o_gain_correction;
  logic [7:0] o_config0;
  logic [7:0] o_config1;
  int failures;
  int checked;

  adc_serial_command_decoder #(.ID_CODE(ID_VAL), .FIFO_WORDS(FIFO_DEPTH)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sclk(i_sclk), .i_din(i_din),
    .o_dout(o_dout), .o_result_ready_n(o_result_ready_n),
    .i_power_down_n(i_power_down_n), .i_conv_valid(i_conv_valid),
    .i_conv_data(i_conv_data), .o_conv_ready(o_conv_ready),
    .o_conv_restart(o_conv_restart), .o_standby(o_standby),
    .o_gain_bypass(o_gain_bypass), .o_corr_enable(o_corr_enable),
    .o_offset_correction(o_offset_correction), .o_gain_correction(o_gain_correction),
    .o_config0(o_config0), .o_config1(o_config1));

  host_model host_u (.o_sclk(i_sclk), .o_din(i_din), .i_dout(o_dout));

  initial
  begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  // ==========================================================
  // Shared tasks
  task finish_test;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task cmp_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task cmp_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Ends off the rising edge so later samples never race updates
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    host_u.xfer(tx, rx);
    @(negedge i_sys_clk);
  endtask
  task send(input logic [7:0] b);
    logic [7:0] rx;
    xfer(b, rx);
  endtask
  task push(input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_conv_valid <= 1'b1;
    i_conv_data <= d;
    do
    begin
      @(posedge i_sys_clk);
      n++;
    end
    while (o_conv_ready !== 1'b1 && n < 50);
    i_conv_valid <= 1'b0;
  endtask
  task push_n(input int n, input logic [31:0] d);
    for (int i = 0; i < n; i++)
      push(d);
  endtask
  task check_ready(input logic exp);
    int n;
    n = 0;
    while (o_result_ready_n !== 1'b0 && n < 12)
    begin
      @(negedge i_sys_clk);
      n++;
    end
    cmp_bit("result_ready_n", exp, o_result_ready_n);
  endtask
  task read_word(input logic [31:0] exp);
    logic [31:0] w;
    logic [7:0] rx;
    for (int i = 0; i < 4; i++)
    begin
      xfer(8'h00, rx);
      w = {w[23:0], rx};
    end
    cmp_vec("result_word", exp, w);
    xfer(8'h00, rx);
    cmp_vec("after_word", 32'h0, rx);
  endtask
  task read_regs(input logic [7:0] op, input int n, input logic [23:0] exp);
    logic [7:0] rx;
    send(op);
    send(8'(n - 1));
    for (int i = 0; i < n; i++)
    begin
      xfer(8'h00, rx);
      cmp_vec("reg_byte", exp[23-8*i -: 8], rx);
    end
  endtask
  task write_regs(input logic [7:0] op, input int n, input logic [23:0] data);
    send(op);
    send(8'(n - 1));
    for (int i = 0; i < n; i++)
      send(data[23-8*i -: 8]);
  endtask

  // ==========================================================
  // Scenarios
  task t_reset_values;
    cmp_vec("config0", 8'h52, o_config0);
    cmp_vec("config1", 8'h08, o_config1);
    cmp_vec("offset", 24'h000000, o_offset_correction);
    cmp_vec("gain", 24'h400000, o_gain_correction);
    cmp_bit("result_ready_n", 1'b1, o_result_ready_n);
    cmp_bit("conv_ready", 1'b1, o_conv_ready);
  endtask
  task t_read_regs;
    send(8'h11);
    read_regs(8'h20, 3, {ID_VAL, 4'h0, 8'h52, 8'h08});
    read_regs(8'h2A, 2, 24'h400000);
  endtask
  task t_write_regs;
    write_regs(8'h45, 3, 24'h112233);
    cmp_vec("offset", 24'h332211, o_offset_correction);
    write_regs(8'h41, 1, 24'h510000);
    cmp_bit("corr_enable", 1'b0, o_corr_enable);
    send(8'h10);
    push_n(63, 32'h0);
    check_ready(1'b1);
    push(32'hA5C3_0F81);
    check_ready(1'b0);
    read_word(32'hA5C3_0F81);
  endtask
  task t_reset_cmd;
    send(8'h11);
    send(8'h07);
    cmp_vec("config0", 8'h52, o_config0);
    cmp_vec("offset", 24'h000000, o_offset_correction);
    push(32'h1234_5678);
    check_ready(1'b0);
    read_word(32'h1234_5678);
  endtask
  task t_stop_single;
    send(8'h11);
    push(32'h0BAD_F00D);
    check_ready(1'b1);
    send(8'h12);
    push(32'h7E57_C0DE);
    check_ready(1'b0);
    read_word(32'h7E57_C0DE);
    push(32'h0BAD_F00D);
    check_ready(1'b1);
  endtask
  task t_standby;
    int n;
    send(8'h03);
    cmp_bit("standby", 1'b1, o_standby);
    n = 0;
    @(posedge i_sys_clk);
    i_conv_valid <= 1'b1;
    i_conv_data <= 32'h0F0F_0F0F;
    repeat (10)
    begin
      @(posedge i_sys_clk);
      if (o_conv_ready === 1'b1)
        n++;
    end
    i_conv_valid <= 1'b0;
    cmp_vec("words_taken", FIFO_DEPTH, n);
    send(8'h01);
    cmp_bit("standby", 1'b0, o_standby);
    cmp_bit("conv_ready", 1'b1, o_conv_ready);
    send(8'h00);
    cmp_bit("standby", 1'b0, o_standby);
    cmp_vec("config0", 8'h52, o_config0);
  endtask
  task t_power_down;
    write_regs(8'h42, 1, 24'h0C0000);
    cmp_vec("config1", 8'h0C, o_config1);
    @(posedge i_sys_clk);
    i_power_down_n <= 1'b0;
    repeat (10) @(posedge i_sys_clk);
    cmp_bit("standby", 1'b1, o_standby);
    cmp_vec("config1", 8'h08, o_config1);
    cmp_bit("conv_restart", 1'b1, o_conv_restart);
    i_power_down_n <= 1'b1;
    repeat (10) @(posedge i_sys_clk);
    cmp_bit("standby", 1'b0, o_standby);
  endtask
  task t_sync_cal;
    logic [7:0] code;
    send(8'h11);
    send(8'h05);
    send(8'h10);
    push_n(64, 32'h0);
    check_ready(1'b1);
    push(32'h0);
    check_ready(1'b0);
    for (int k = 0; k < 2; k++)
    begin
      code = (k == 0) ? 8'h60 : 8'h61;
      send(8'h11);
      send(code);
      cmp_bit("gain_bypass", k == 0, o_gain_bypass);
      send(8'h10);
      push_n(16, (k == 0) ? 32'hFEDC_BA98 : 32'h1234_5678);
      push(32'h0);
      check_ready(1'b0);
      cmp_vec("offset", 24'hFEDCBA, o_offset_correction);
      if (k == 1)
        cmp_vec("gain", 24'h123456, o_gain_correction);
      cmp_bit("gain_bypass", 1'b0, o_gain_bypass);
    end
  endtask

  // Full run is near 16k clocks; a hang is cut at 50k
  initial
  begin
    #200000;
    failures++;
    finish_test;
  end

  initial
  begin
    failures = 0;
    checked = 0;
    i_rst = 1'b1;
    i_power_down_n = 1'b1;
    i_conv_valid = 1'b0;
    i_conv_data = 32'h0;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    t_reset_values;
    t_read_regs;
    t_write_regs;
    t_reset_cmd;
    t_stop_single;
    t_standby;
    t_power_down;
    t_sync_cal;
    finish_test;
  end
endmodule
`default_nettype wire
